// *** shared/fifo_defs.svh ***
// Width, depth, offset and timing constants of the deep buffer
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH

// Storage organisation: 262,144 words of 9 bits
`define FIFO_DW 9
`define FIFO_AW 18
`define FIFO_CW 19
`define FIFO_DEPTH 19'h4_0000
`define FIFO_HALF 19'h2_0000
`define PTR_FIRST 18'h0_0000
`define CNT_ZERO 19'h0_0000
`define DATA_ZERO 9'h000

// Default flag offsets
`define OFF_SHORT 18'h0_007F
`define OFF_LONG 18'h0_03FF

// Offset word slices, nine bits each
`define OFF_LO_MSB 8
`define OFF_HI_LSB 9
`define PART_EMPTY_LO 2'h0
`define PART_EMPTY_HI 2'h1
`define PART_FULL_LO 2'h2
`define PART_FULL_HI 2'h3
`define IDX_ZERO 2'h0
`define IDX_STEP 2'h1

// Read clock transitions before a fall-through word shows
`define FALL_LAST 2'h2
`define FALL_STEP 2'h1
`define FALL_ZERO 2'h0

`endif

// *** shared/fifo_pkg.sv ***
// Types shared by the deep buffer design files
`include "fifo_defs.svh"

package fifo_pkg;

	// Timing mode caught during master reset
	typedef enum logic {
		MODE_STANDARD = 1'b0,
		MODE_FALL = 1'b1
	} timingMode_e;

	// Offset programming method caught during master reset
	typedef enum logic {
		PROG_PARALLEL = 1'b0,
		PROG_SERIAL = 1'b1
	} progMethod_e;

	// All pins that arrive from outside the reference clock domain
	typedef struct packed {
		logic writeClk;
		logic readClk;
		logic writeEnN;
		logic readEnN;
		logic serialEnN;
		logic loadN;
		logic modeSerial;
		logic retransmitN;
		logic masterResetN;
		logic partialResetN;
		logic outEnN;
		logic [`FIFO_DW-1:0] dataIn;
	} pin_s;

endpackage : fifo_pkg

// *** rtl/fifo_store_mem.sv ***
// Word storage of the deep buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defs.svh"

module fifo_store_mem (
	// Clock
	input wire logic clk,
	// Write side
	input wire logic wrEn,
	input wire logic [`FIFO_AW-1:0] wrAddr,
	input wire logic [`FIFO_DW-1:0] wrData,
	// Read side
	input wire logic [`FIFO_AW-1:0] rdAddr,
	output logic [`FIFO_DW-1:0] rdData
);

	logic [`FIFO_DW-1:0] store [0:(1<<`FIFO_AW)-1];

	// Write port
	always_ff @(posedge clk) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
	end

	// Read port, one cycle behind the address
	always_ff @(posedge clk) begin
		rdData <= store[rdAddr];
	end

endmodule : fifo_store_mem
`default_nettype wire

// *** rtl/dual_clock_deep_fifo.sv ***
// Deep 9-bit buffer with sampled write and read clocks and status flags
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defs.svh"

// How it works
// [RL1] Storage holds 262,144 words of nine bits, depth fixed per variant.
// [RL2] A write clock rise with write enable low stores the input word.
// [RL3] A read clock rise with read enable low moves the next word out.
// [RL4] Write and read clocks are unrelated and may stop at any time.
// [RL5] Standard mode keeps a new word off the outputs until an explicit read.
// [RL6] Fall-through mode shows the first word after three read clock transitions.
// [RL7] In fall-through mode later words need read enable low to appear.
// [RL8] Mode pin level during master reset picks the timing mode for good.
// [RL9] Shared flag pins are empty/full or output-ready/input-ready by mode.
// [RL10] Almost-empty and almost-full thresholds live in separate offset registers.
// [RL11] Default thresholds sit 127 or 1,023 words from the boundaries.
// [RL12] Load pin at master reset picks 127 parallel or 1,023 serial.
// [RL13] Serial enable and load low shift one serial bit per write clock.
// [RL14] Write enable and load low load offsets from the data inputs.
// [RL15] Read enable and load low put offset contents on the outputs.
// [RL16] Master reset returns both pointers to the first location.
// [RL17] After master reset the flags follow the chosen mode and offsets.
// [RL18] Partial reset returns both pointers to the first location.
// [RL19] Partial reset keeps mode, method and offsets, flags recomputed.
// [RL20] Retransmit low at a read clock rise rewinds the read pointer.
// [RL21] Output enable alone decides whether the data outputs are driven.
// [RL22] Fall-through mode lets outputs feed the next buffer directly.
// [RL23] Retransmit keeps write side and settings, shows empty for a while.
// [RL24] Both resets clear the output register to zero.
// [RL25] Almost-empty goes low while the word count is below the empty offset.
// [RL26] Almost-full goes low while the count exceeds capacity minus full offset.
// [RL27] Writes when full and reads when empty are ignored.
// [RL28] Half-full goes low while the count exceeds half the capacity.
module dual_clock_deep_fifo
	import fifo_pkg::*;
(
	// Reference clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Write port
	input wire logic writeClk,
	input wire logic writeEnN,
	input wire logic [`FIFO_DW-1:0] data_in,
	input wire logic serial_enable_n,
	input wire logic load_select_n,
	input wire logic mode_select_serial_pin,
	// Read port
	input wire logic readClk,
	input wire logic readEnN,
	input wire logic retransmit_n,
	input wire logic outEnN,
	// Resets from the pins
	input wire logic master_reset_n,
	input wire logic partial_reset_n,
	// Data outputs
	output logic [`FIFO_DW-1:0] data_out,
	output logic dataOutEn,
	// Status flags, all active low
	output logic empty_out_valid_flag,
	output logic full_in_space_flag,
	output logic half_full_flag,
	output logic almost_empty_flag,
	output logic almost_full_flag
);

	// Pointer step with wrap
	function automatic logic [`FIFO_AW-1:0] nextPtr(input logic [`FIFO_AW-1:0] ptr);
		nextPtr = ptr + {{(`FIFO_AW-1){1'b0}}, 1'b1};
	endfunction : nextPtr

	// Nine-bit slice of the offset pair picked by an index
	function automatic logic [`FIFO_DW-1:0] offsetPart(input logic [1:0] idx,
		input logic [`FIFO_AW-1:0] emptyVal, input logic [`FIFO_AW-1:0] fullVal);
		case (idx)
			`PART_EMPTY_LO: offsetPart = emptyVal[`OFF_LO_MSB:0];
			`PART_EMPTY_HI: offsetPart = emptyVal[`FIFO_AW-1:`OFF_HI_LSB];
			`PART_FULL_LO: offsetPart = fullVal[`OFF_LO_MSB:0];
			default: offsetPart = fullVal[`FIFO_AW-1:`OFF_HI_LSB];
		endcase
	endfunction : offsetPart

	pin_s pinRaw;
	pin_s syncA;
	pin_s syncB;
	pin_s syncC;
	pin_s pinStable;
	timingMode_e mode;
	progMethod_e method;
	logic [`FIFO_AW-1:0] emptyOff;
	logic [`FIFO_AW-1:0] fullOff;
	logic [`FIFO_AW-1:0] wPtr;
	logic [`FIFO_AW-1:0] rPtr;
	logic [`FIFO_CW-1:0] count;
	logic [`FIFO_DW-1:0] dataOut;
	logic [`FIFO_DW-1:0] memRdata;
	logic outValid;
	logic fetchPend;
	logic rtHold;
	logic [1:0] wrIdx;
	logic [1:0] rdIdx;
	logic [1:0] fallCnt;

	// Gather the asynchronous pins
	assign pinRaw = {writeClk, readClk, writeEnN, readEnN, serial_enable_n, load_select_n,
		mode_select_serial_pin, retransmit_n, master_reset_n, partial_reset_n, outEnN, data_in};

	// Three-stage sampling; a change counts once stages two and three agree
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			syncA <= '0;
			syncB <= '0;
			syncC <= '0;
			pinStable <= '0;
		end else begin
			syncA <= pinRaw;
			syncB <= syncA;
			syncC <= syncB;
			pinStable <= pin_s'((syncB & ~(syncB ^ syncC)) | (pinStable & (syncB ^ syncC))); // see [RL4]
		end
	end

	// Link clock edges found from the agreed samples
	wire wEdge = syncB.writeClk & syncC.writeClk & ~pinStable.writeClk; // see [RL4]
	wire rEdge = syncB.readClk & syncC.readClk & ~pinStable.readClk;
	wire rToggle = ~(syncB.readClk ^ syncC.readClk) & (syncB.readClk ^ pinStable.readClk);

	// Reset and status decode
	wire mrsActive = ~pinStable.masterResetN;
	wire prsActive = ~pinStable.partialResetN;
	wire resetting = mrsActive | prsActive;
	wire isEmpty = (count == `CNT_ZERO);
	wire isFull = (count == `FIFO_DEPTH);
	wire isStd = (mode == MODE_STANDARD);

	// Write side requests
	wire doWrite = wEdge & ~pinStable.writeEnN & pinStable.loadN & ~isFull & ~resetting; // see [RL2] [RL27]
	wire doParLoad = wEdge & ~pinStable.writeEnN & ~pinStable.loadN & (method == PROG_PARALLEL) & ~resetting;
	wire doSerLoad = wEdge & ~pinStable.serialEnN & ~pinStable.loadN & (method == PROG_SERIAL) & ~resetting;

	// Read side requests
	wire rtEvent = rEdge & ~pinStable.retransmitN & ~resetting; // see [RL20]
	wire readReq = rEdge & ~pinStable.readEnN & pinStable.loadN & ~resetting & ~rtEvent;
	wire offRead = rEdge & ~pinStable.readEnN & ~pinStable.loadN & ~resetting & ~rtEvent; // see [RL15]
	wire stdRead = readReq & isStd & ~isEmpty; // see [RL3] [RL5] [RL27]
	wire fallRead = readReq & ~isStd & outValid & ~isEmpty; // see [RL7]
	wire fallDrain = readReq & ~isStd & outValid & isEmpty;
	wire fallWait = ~isStd & ~outValid & ~fetchPend & ~isEmpty & ~resetting & ~rtEvent;
	wire autoFetch = fallWait & rToggle & (fallCnt == `FALL_LAST); // see [RL6]
	wire doFetch = stdRead | fallRead | autoFetch;

	// Count bookkeeping
	wire [`FIFO_CW-1:0] next_count = count + {{(`FIFO_CW-1){1'b0}}, doWrite} - {{(`FIFO_CW-1){1'b0}}, doFetch};
	wire [`FIFO_CW-1:0] rtCount = isFull ? count : ({1'b0, wPtr} + {{(`FIFO_CW-1){1'b0}}, doWrite});

	// Flag thresholds
	wire halfHit = (count > `FIFO_HALF); // see [RL28]
	wire almostEmptyHit = (count < {1'b0, emptyOff}); // see [RL25]
	wire almostFullHit = (count > (`FIFO_DEPTH - {1'b0, fullOff})); // see [RL26]
	wire next_emptyPin = isStd ? ~(isEmpty | rtHold) : ~outValid; // see [RL9] [RL23]
	wire next_fullPin = isStd ? ~isFull : isFull;

	// Word storage
	fifo_store_mem storeMem ( // see [RL1]
		.clk(ref_clk),
		.wrEn(doWrite),
		.wrAddr(wPtr),
		.wrData(pinStable.dataIn),
		.rdAddr(rPtr),
		.rdData(memRdata)
	);

	// Mode, method and offsets; only rstn and master reset reload defaults
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode <= MODE_STANDARD;
			method <= PROG_PARALLEL;
			emptyOff <= `OFF_SHORT;
			fullOff <= `OFF_SHORT;
		end else if (mrsActive) begin
			mode <= timingMode_e'(pinStable.modeSerial); // see [RL8]
			method <= progMethod_e'(pinStable.loadN); // see [RL12]
			emptyOff <= pinStable.loadN ? `OFF_LONG : `OFF_SHORT; // see [RL11]
			fullOff <= pinStable.loadN ? `OFF_LONG : `OFF_SHORT;
		end else if (doSerLoad) begin
			{fullOff, emptyOff} <= {pinStable.modeSerial, fullOff, emptyOff[`FIFO_AW-1:1]}; // see [RL13] [RL10]
		end else if (doParLoad) begin
			case (wrIdx) // see [RL14]
				`PART_EMPTY_LO: emptyOff[`OFF_LO_MSB:0] <= pinStable.dataIn;
				`PART_EMPTY_HI: emptyOff[`FIFO_AW-1:`OFF_HI_LSB] <= pinStable.dataIn;
				`PART_FULL_LO: fullOff[`OFF_LO_MSB:0] <= pinStable.dataIn;
				default: fullOff[`FIFO_AW-1:`OFF_HI_LSB] <= pinStable.dataIn;
			endcase
		end
	end

	// Offset slice indexes for parallel load and read back
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wrIdx <= `IDX_ZERO;
			rdIdx <= `IDX_ZERO;
		end else if (resetting) begin
			wrIdx <= `IDX_ZERO;
			rdIdx <= `IDX_ZERO;
		end else begin
			wrIdx <= doParLoad ? wrIdx + `IDX_STEP : wrIdx;
			rdIdx <= offRead ? rdIdx + `IDX_STEP : rdIdx;
		end
	end

	// Write pointer
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wPtr <= `PTR_FIRST;
		end else if (resetting) begin
			wPtr <= `PTR_FIRST; // see [RL16] [RL18]
		end else if (doWrite) begin
			wPtr <= nextPtr(wPtr);
		end
	end

	// Read pointer and word count
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rPtr <= `PTR_FIRST;
			count <= `CNT_ZERO;
		end else if (resetting) begin
			rPtr <= `PTR_FIRST; // see [RL16] [RL18]
			count <= `CNT_ZERO;
		end else if (rtEvent) begin
			rPtr <= `PTR_FIRST; // see [RL20] [RL23]
			count <= rtCount;
		end else begin
			rPtr <= doFetch ? nextPtr(rPtr) : rPtr;
			count <= next_count;
		end
	end

	// Fall-through delay counter over read clock transitions
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fallCnt <= `FALL_ZERO;
		end else if (!fallWait) begin
			fallCnt <= `FALL_ZERO;
		end else if (rToggle) begin
			fallCnt <= autoFetch ? `FALL_ZERO : fallCnt + `FALL_STEP; // see [RL6]
		end
	end

	// Output register, valid flag and retransmit hold
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dataOut <= `DATA_ZERO;
			outValid <= 1'b0;
			fetchPend <= 1'b0;
			rtHold <= 1'b0;
		end else if (resetting) begin
			dataOut <= `DATA_ZERO; // see [RL24]
			outValid <= 1'b0;
			fetchPend <= 1'b0;
			rtHold <= 1'b0;
		end else begin
			fetchPend <= doFetch;
			rtHold <= rtEvent | (rtHold & ~rEdge); // see [RL23]
			if (fetchPend) begin
				dataOut <= memRdata; // see [RL3]
				outValid <= 1'b1;
			end else if (offRead) begin
				dataOut <= offsetPart(rdIdx, emptyOff, fullOff); // see [RL15]
			end else if (rtEvent | fallDrain) begin
				outValid <= 1'b0;
			end
		end
	end

	// Registered flag pins, recomputed from mode and offsets in force
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			empty_out_valid_flag <= 1'b0;
			full_in_space_flag <= 1'b1;
			half_full_flag <= 1'b1;
			almost_empty_flag <= 1'b0;
			almost_full_flag <= 1'b1;
		end else begin
			empty_out_valid_flag <= next_emptyPin; // see [RL9] [RL17] [RL19]
			full_in_space_flag <= next_fullPin;
			half_full_flag <= ~halfHit;
			almost_empty_flag <= ~almostEmptyHit;
			almost_full_flag <= ~almostFullHit;
		end
	end

	// Data pins; in fall-through mode they feed a following buffer directly
	assign data_out = dataOut; // see [RL22]
	assign dataOutEn = ~pinStable.outEnN; // see [RL21]

	// Checks on reset behaviour
	AST_PTR_MRS: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL16]
		mrsActive |=> (wPtr == `PTR_FIRST) && (rPtr == `PTR_FIRST) && (count == `CNT_ZERO))
		else $error("pointers not cleared by master reset");
	AST_OUT_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL24]
		resetting |=> (dataOut == `DATA_ZERO) && !outValid)
		else $error("output register not cleared by reset");
	AST_MODE_KEEP: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL8]
		!mrsActive |=> $stable(mode) && $stable(method))
		else $error("mode or method changed outside master reset");
	AST_PRS_OFFSETS: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL19]
		(prsActive && !mrsActive) |=> $stable(emptyOff) && $stable(fullOff))
		else $error("partial reset disturbed the offsets");
	AST_PTR_PRS: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL18]
		(prsActive && !mrsActive) |=> (wPtr == `PTR_FIRST) && (rPtr == `PTR_FIRST) && (count == `CNT_ZERO))
		else $error("pointers not cleared by partial reset");
	// Rewind touches only the read side
	AST_RT_WPTR: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL23]
		(rtEvent && !doWrite) |=> (wPtr == $past(wPtr)))
		else $error("retransmit moved the write pointer");

	// Checks on data movement
	AST_STD_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL5]
		(!fetchPend && !offRead && !resetting) |=> $stable(dataOut))
		else $error("output word changed without a read");
	AST_FULL_BLOCK: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL27]
		(wEdge && isFull && !resetting) |=> (wPtr == $past(wPtr)) && isFull)
		else $error("write accepted while full");
	AST_FALL_LATENCY: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL6]
		autoFetch |=> fetchPend ##1 outValid ##1 !empty_out_valid_flag)
		else $error("fall-through word not presented");
	AST_RT_EMPTY: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL23]
		(rtEvent && isStd) |=> (rPtr == `PTR_FIRST) ##1 !empty_out_valid_flag)
		else $error("retransmit did not rewind or show empty");

	// Checks on status flags
	AST_HALF: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL28]
		halfHit |=> !half_full_flag)
		else $error("half-full flag not low");
	AST_ALMOST_EMPTY: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL25]
		(count < {1'b0, emptyOff}) |=> !almost_empty_flag)
		else $error("almost-empty flag not low");
	AST_ALMOST_FULL: assert property (@(posedge ref_clk) disable iff (!rstn) // see [RL26]
		(count > (`FIFO_DEPTH - {1'b0, fullOff})) |=> !almost_full_flag)
		else $error("almost-full flag not low");

endmodule : dual_clock_deep_fifo
`default_nettype wire

// *** bench/fifo_peer.sv ***
// Producer and consumer model driving the write and read ports
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defs.svh"

module fifo_peer
	import fifo_pkg::*;
(
	// Write port
	output logic writeClk,
	output logic writeEnN,
	output logic [`FIFO_DW-1:0] data_in,
	output logic serial_enable_n,
	// Read port
	output logic readClk,
	output logic readEnN,
	output logic retransmit_n
);
	// Idle levels, clocks stand still between transfers
	initial begin
		writeClk = 1'b0;
		writeEnN = 1'b1;
		data_in = 9'h0AA;
		serial_enable_n = 1'b1;
		readClk = 1'b0;
		readEnN = 1'b1;
		retransmit_n = 1'b1;
	end

	// One 837 ns write clock period, controls held across the rise
	task automatic wr(input logic [`FIFO_DW-1:0] d);
		#37;
		writeEnN = 1'b0;
		data_in = d;
		#400 writeClk = 1'b1;
		#400 writeClk = 1'b0;
		writeEnN = 1'b1;
		data_in = ~d; // Released bus shows the inverse word
	endtask : wr

	// One write clock period with serial enable low
	task automatic sh();
		#37;
		serial_enable_n = 1'b0;
		#400 writeClk = 1'b1;
		#400 writeClk = 1'b0;
		serial_enable_n = 1'b1;
	endtask : sh

	// One 837 ns read clock period with chosen enable and rewind
	task automatic rd(input logic reN, input logic rtN);
		#37;
		readEnN = reN;
		retransmit_n = rtN;
		#400 readClk = 1'b1;
		#400 readClk = 1'b0;
		readEnN = 1'b1;
		retransmit_n = 1'b1;
	endtask : rd
endmodule : fifo_peer
`default_nettype wire

// *** bench/dual_clock_deep_fifo_tb_top.sv ***
// Self-checking bench for the deep dual-clock buffer
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defs.svh"

module dual_clock_deep_fifo_tb_top
	import fifo_pkg::*;
;
	logic ref_clk, rstn, load_select_n, mode_select_serial_pin, outEnN, master_reset_n, partial_reset_n;
	wire writeClk, writeEnN, serial_enable_n, readClk, readEnN, retransmit_n, dataOutEn;
	wire empty_out_valid_flag, full_in_space_flag, half_full_flag, almost_empty_flag, almost_full_flag;
	wire [`FIFO_DW-1:0] data_in, data_out;
	int errors = 0;
	int checkCount = 0;
	logic [`FIFO_DW-1:0] offs [4] = '{9'h002, 9'h000, 9'h005, 9'h000};
	logic [`FIFO_DW-1:0] words [3] = '{9'h1A5, 9'h0B2, 9'h14C};
	logic [35:0] serialWord = {18'h0_0100, 18'h0_0003};

	// Reference clock, 100 ns period
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;

	// Device and its far-side partner
	dual_clock_deep_fifo u_dual_clock_deep_fifo (.ref_clk(ref_clk), .rstn(rstn), .writeClk(writeClk),
		.writeEnN(writeEnN), .data_in(data_in), .serial_enable_n(serial_enable_n),
		.load_select_n(load_select_n), .mode_select_serial_pin(mode_select_serial_pin), .readClk(readClk),
		.readEnN(readEnN), .retransmit_n(retransmit_n), .outEnN(outEnN), .master_reset_n(master_reset_n),
		.partial_reset_n(partial_reset_n), .data_out(data_out), .dataOutEn(dataOutEn),
		.empty_out_valid_flag(empty_out_valid_flag), .full_in_space_flag(full_in_space_flag),
		.half_full_flag(half_full_flag), .almost_empty_flag(almost_empty_flag),
		.almost_full_flag(almost_full_flag));
	fifo_peer u_fifo_peer (.writeClk(writeClk), .writeEnN(writeEnN), .data_in(data_in),
		.serial_enable_n(serial_enable_n), .readClk(readClk), .readEnN(readEnN), .retransmit_n(retransmit_n));

	// Compare and count
	task automatic chk(input logic [`FIFO_DW-1:0] got, input logic [`FIFO_DW-1:0] exp);
		checkCount++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Wait n edges, then sample mid-cycle
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : wt

	// Read one word and compare the output register
	task automatic rdchk(input logic [`FIFO_DW-1:0] exp);
		u_fifo_peer.rd(1'b0, 1'b1);
		wt(2);
		chk(data_out, exp);
	endtask : rdchk

	// Master or partial reset pulse with mode and load levels
	task automatic pin_reset(input logic full, input logic md, input logic ldN);
		@(posedge ref_clk);
		mode_select_serial_pin <= md;
		load_select_n <= ldN;
		if (full) begin
			master_reset_n <= 1'b0;
		end else begin
			partial_reset_n <= 1'b0;
		end
		repeat (10) @(posedge ref_clk);
		master_reset_n <= 1'b1;
		partial_reset_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		load_select_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask : pin_reset

	task automatic done(input string name);
		$display("test %s finished, errors so far %0d", name, errors);
	endtask : done

	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d, errors %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// Cut a hang short
	initial begin
		#300_000;
		errors++;
		report_and_stop();
	end

	// Test sequence
	initial begin
		rstn = 1'b0;
		master_reset_n = 1'b0;
		partial_reset_n = 1'b1;
		load_select_n = 1'b0;
		mode_select_serial_pin = 1'b0;
		outEnN = 1'b0;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		pin_reset(1'b1, 1'b0, 1'b0);
		wt(1);
		chk(data_out, 9'h000);
		chk(9'(empty_out_valid_flag), 9'h000);
		chk(9'(full_in_space_flag), 9'h001);
		chk(9'(half_full_flag), 9'h001);
		chk(9'(almost_empty_flag), 9'h000);
		chk(9'(almost_full_flag), 9'h001);
		done("defaults");
		// Parallel offset load and read-back
		@(posedge ref_clk);
		load_select_n <= 1'b0;
		foreach (offs[i]) u_fifo_peer.wr(offs[i]);
		foreach (offs[i]) rdchk(offs[i]);
		@(posedge ref_clk);
		load_select_n <= 1'b1;
		done("offsets");
		// Standard mode writes, reads, rewind and empty read
		foreach (words[i]) u_fifo_peer.wr(words[i]);
		wt(6);
		chk(data_out, 9'h000);
		chk(9'(empty_out_valid_flag), 9'h001);
		chk(9'(almost_empty_flag), 9'h001);
		rdchk(words[0]);
		u_fifo_peer.rd(1'b1, 1'b0);
		wt(2);
		chk(9'(empty_out_valid_flag), 9'h000);
		u_fifo_peer.rd(1'b1, 1'b1);
		foreach (words[i]) rdchk(words[i]);
		wt(4);
		chk(9'(empty_out_valid_flag), 9'h000);
		rdchk(words[2]);
		done("standard");
		// Output enable alone drives the outputs
		@(posedge ref_clk);
		outEnN <= 1'b1;
		wt(4);
		chk(9'(dataOutEn), 9'h000);
		@(posedge ref_clk);
		outEnN <= 1'b0;
		wt(4);
		chk(9'(dataOutEn), 9'h001);
		done("output enable");
		// Partial reset keeps offsets, clears pointers and output
		u_fifo_peer.wr(9'h0C3);
		pin_reset(1'b0, 1'b0, 1'b1);
		wt(1);
		chk(data_out, 9'h000);
		chk(9'(empty_out_valid_flag), 9'h000);
		u_fifo_peer.wr(words[0]);
		u_fifo_peer.wr(words[1]);
		wt(6);
		chk(9'(almost_empty_flag), 9'h001);
		rdchk(words[0]);
		done("partial reset");
		// Fall-through mode with long defaults
		pin_reset(1'b1, 1'b1, 1'b1);
		wt(1);
		chk(data_out, 9'h000);
		chk(9'(empty_out_valid_flag), 9'h001);
		chk(9'(full_in_space_flag), 9'h000);
		u_fifo_peer.wr(words[1]);
		u_fifo_peer.wr(words[2]);
		u_fifo_peer.rd(1'b1, 1'b1);
		u_fifo_peer.rd(1'b1, 1'b1);
		wt(4);
		chk(data_out, words[1]);
		chk(9'(empty_out_valid_flag), 9'h000);
		chk(9'(almost_empty_flag), 9'h000);
		rdchk(words[2]);
		done("fall-through");
		// Serial offset load, first bit into the lowest empty bit, then read back
		@(posedge ref_clk);
		load_select_n <= 1'b0;
		for (int i = 0; i < 36; i++) begin
			@(posedge ref_clk);
			mode_select_serial_pin <= serialWord[i];
			u_fifo_peer.sh();
		end
		for (int i = 0; i < 4; i++) rdchk(serialWord[9*i +: 9]);
		@(posedge ref_clk);
		load_select_n <= 1'b1;
		done("serial offsets");
		report_and_stop();
	end
endmodule : dual_clock_deep_fifo_tb_top
`default_nettype wire
